// File: rtl/card_mode_pin_function_map.sv
// routes mode dependent connector pins 24 and 31..50, plus the address lines, to card internal functions
`timescale 1ns/1ps
`default_nettype none
`include "pin_map_defs.svh"
module card_mode_pin_function_map (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire pin_map_pkg::card_mode_t       mode,
    input  wire pin_map_pkg::udma_dir_t        udma_dir,
    input  wire logic                          host_is_8bit,
    // connector inputs
    input  wire logic                          pin_cs_hi_n,
    input  wire logic                          pin34,
    input  wire logic                          pin35,
    input  wire logic                          pin36,
    input  wire logic                          pin39,
    input  wire logic                          pin44,
    input  wire logic [`PC_ADDR_W-1:0]         pin_addr,
    // card side outputs toward the connector
    input  wire logic                          core_ready,
    input  wire logic                          core_wait_n,
    input  wire logic                          core_dev_ready_n,
    input  wire logic                          core_dev_strobe,
    input  wire logic                          core_ack_n,
    input  wire logic                          core_dma_req,
    input  wire logic                          core_is16_n,
    output logic                               pin42,
    output logic                               pin43,
    output logic                               pin24,
    // decoded functions for the card core
    output logic                               read_strobe_n,
    output logic                               write_strobe_n,
    output logic                               host_strobe,
    output logic                               host_ready_n,
    output logic                               stop,
    output logic                               write_enable_n,
    output logic                               attr_select_n,
    output logic                               dma_ack_n,
    output logic                               cable_select_n,
    output logic                               cs_hi_n,
    output logic [`PC_ADDR_W-1:0]              reg_addr,
    output logic [`TF_ADDR_W-1:0]              tf_index
);
    localparam int NIN = 6 + `PC_ADDR_W;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn;
    logic           is_ide;
    logic           s34;
    logic           s35;
    logic           s36;
    logic           s39;
    logic           s44;
    logic           s_cs;
    logic [`PC_ADDR_W-1:0] s_addr;

    assign raw_in = {pin34, pin35, pin36, pin39, pin44, pin_cs_hi_n,
                     pin_addr};

    pin_sync #(.W(NIN)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign s34    = syn[NIN-1];
    assign s35    = syn[NIN-2];
    assign s36    = syn[NIN-3];
    assign s39    = syn[NIN-4];
    assign s44    = syn[NIN-5];
    assign s_cs   = syn[NIN-6];
    assign s_addr = syn[`PC_ADDR_W-1:0];
    assign is_ide = (mode == pin_map_pkg::mode_ide);

    // host strobes: pin 34/35 meaning depends on mode and burst direction
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            host_strobe    <= 1'b1;
            host_ready_n   <= 1'b1;
            stop           <= 1'b0;
        end else begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            host_strobe    <= 1'b1;
            host_ready_n   <= 1'b1;
            stop           <= 1'b0;
            if (!is_ide || udma_dir == pin_map_pkg::udma_none) begin
                read_strobe_n  <= s34;
                write_strobe_n <= s35;
            end else if (udma_dir == pin_map_pkg::udma_write) begin
                host_strobe <= s34;
                stop        <= s35;
            end else begin
                host_ready_n <= s34;
                stop         <= s35;
            end
        end
    end

    // pin 42: wait in pc modes, ready / ddma ready / dstrobe in ide
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin42 <= 1'b1;
        end else if (!is_ide) begin
            pin42 <= core_wait_n;
        end else begin
            case (udma_dir)
                pin_map_pkg::udma_none:  pin42 <= core_ready;
                pin_map_pkg::udma_write: pin42 <= core_dev_ready_n;
                pin_map_pkg::udma_read:  pin42 <= core_dev_strobe;
                default:                 pin42 <= 1'b1;
            endcase
        end
    end

    // pins 43 and 44 swap between pc card and dma roles
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin43         <= 1'b1;
            attr_select_n <= 1'b1;
            dma_ack_n     <= 1'b1;
        end else if (is_ide) begin
            pin43         <= core_dma_req;
            attr_select_n <= 1'b1;
            dma_ack_n     <= s44;
        end else begin
            pin43         <= core_ack_n;
            attr_select_n <= s44;
            dma_ack_n     <= 1'b1;
        end
    end

    // cable select only seen in ide; pc modes ignore pin 39 entirely
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cable_select_n <= 1'b1;
        end else begin
            cable_select_n <= is_ide ? s39 : 1'b1;
        end
    end

    // write enable has no function in ide; host keeps it high anyway
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            write_enable_n <= 1'b1;
        end else begin
            write_enable_n <= is_ide ? 1'b1 : s36;
        end
    end

    // 8 bit hosts leave upper enable floating, so force it inactive
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_hi_n <= 1'b1;
        end else begin
            cs_hi_n <= host_is_8bit ? 1'b1 : s_cs;
        end
    end

    // address: ide uses only the low three bits, upper lines ignored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_addr <= '0;
            tf_index <= '0;
        end else begin
            tf_index <= s_addr[`TF_ADDR_W-1:0];
            reg_addr <= is_ide ? {{(`PC_ADDR_W-`TF_ADDR_W){1'b0}},
                                  s_addr[`TF_ADDR_W-1:0]} : s_addr;
        end
    end

    // 16 bit indication passed as is except in pc memory mode, where pin 24 is held low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin24 <= 1'b1;
        end else begin
            pin24 <= (mode == pin_map_pkg::mode_pc_mem) ? 1'b0
                     : core_is16_n;
        end
    end

    chk_ide_addr_low: assert property (
        @(posedge clk) disable iff (!reset_n)
        is_ide |=> reg_addr[`PC_ADDR_W-1:`TF_ADDR_W] == '0)
        else $error("upper address leaked in ide mode");
    chk_pc_csel_ignored: assert property (
        @(posedge clk) disable iff (!reset_n)
        !is_ide |=> cable_select_n)
        else $error("cable select seen in pc mode");
    chk_udma_w_pin42: assert property (
        @(posedge clk) disable iff (!reset_n)
        (is_ide && udma_dir == pin_map_pkg::udma_write)
        |=> pin42 == $past(core_dev_ready_n))
        else $error("pin 42 not ready in write burst");
    chk_udma_r_pin42: assert property (
        @(posedge clk) disable iff (!reset_n)
        (is_ide && udma_dir == pin_map_pkg::udma_read)
        |=> pin42 == $past(core_dev_strobe))
        else $error("pin 42 not strobe in read burst");
    chk_pio_strobes: assert property (
        @(posedge clk) disable iff (!reset_n)
        (is_ide && udma_dir == pin_map_pkg::udma_none) |=> stop == 1'b0
        && host_strobe && read_strobe_n == $past(s34))
        else $error("pio strobe misrouted");
    chk_pin43_route: assert property (
        @(posedge clk) disable iff (!reset_n)
        is_ide |=> pin43 == $past(core_dma_req))
        else $error("dma request not on pin 43");
    chk_dmack_pc: assert property (
        @(posedge clk) disable iff (!reset_n)
        !is_ide |=> dma_ack_n && attr_select_n == $past(s44))
        else $error("pin 44 misrouted in pc mode");
    chk_we_ide: assert property (
        @(posedge clk) disable iff (!reset_n)
        is_ide |=> write_enable_n)
        else $error("write enable active in ide");
    chk_8bit_cs: assert property (
        @(posedge clk) disable iff (!reset_n)
        host_is_8bit |=> cs_hi_n)
        else $error("upper enable active on 8 bit host");
    cov_udma_write: cover property (@(posedge clk)
        is_ide && udma_dir == pin_map_pkg::udma_write);
    cov_udma_read: cover property (@(posedge clk)
        is_ide && udma_dir == pin_map_pkg::udma_read);
    cov_pc_io: cover property (@(posedge clk)
        mode == pin_map_pkg::mode_pc_io && !attr_select_n);
endmodule : card_mode_pin_function_map
`default_nettype wire

// File: rtl/pin_map_defs.svh
// constants for the card connector pin function map
// Functional notes
// - upper data lines and second enable may sit unused in 8 bit systems
// - cable select ignored in both PC Card modes, no pull-up there
// - IDE without Ultra DMA: pin 34 read, 35 write, 42 ready
// - Ultra DMA write: host strobe 34, stop 35, card ready_n on 42
// - Ultra DMA read: host ready_n 34, stop 35, card strobe on 42
// - 16 bit indication only partly works in PC Card mode
// - IDE mode decodes only address bits 2..0 into eight registers
`ifndef PIN_MAP_DEFS_SVH
`define PIN_MAP_DEFS_SVH
`define TF_ADDR_W 3
`define PC_ADDR_W 11
`define SYNC_DEPTH 3
`define IDLE_HIGH 1'b1
`endif

// File: rtl/pin_map_pkg.sv
// types for the card connector pin function map
package pin_map_pkg;
    typedef enum logic [1:0] {
        mode_pc_mem,
        mode_pc_io,
        mode_ide
    } card_mode_t;
    typedef enum logic [1:0] {
        udma_none,
        udma_write,
        udma_read
    } udma_dir_t;
endpackage : pin_map_pkg

// File: rtl/pin_sync.sv
// three stage synchroniser for connector inputs
`timescale 1ns/1ps
`default_nettype none
`include "pin_map_defs.svh"
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    // only s2 reads s1; a change counts once s2 and s3 agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1 <= {W{`IDLE_HIGH}};
            s2 <= {W{`IDLE_HIGH}};
            s3 <= {W{`IDLE_HIGH}};
            sync_out <= {W{`IDLE_HIGH}};
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    sync_out[i] <= s3[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: verif/card_mode_pin_function_map_bench.sv
// self-checking bench for the connector pin function map
`timescale 1ns/1ps
`default_nettype none
module card_mode_pin_function_map_bench;
    logic clk, reset_n, host_is_8bit, dma_used, a25, rd_n, wr_n, we_n;
    logic csel_n, reg_n, dack_n, cs2_n, core_ready, core_wait_n;
    logic core_dev_ready_n, core_dev_strobe, core_ack_n, core_dma_req;
    logic core_is16_n, pin34, pin35, pin36, pin39, pin44, pin_cs_hi_n;
    logic pin42, pin43, pin24, read_strobe_n, write_strobe_n, host_strobe;
    logic host_ready_n, stop, write_enable_n, attr_select_n, dma_ack_n;
    logic cable_select_n, cs_hi_n;
    logic [10:0] addr, pin_addr, reg_addr;
    logic [2:0]  tf_index;
    pin_map_pkg::card_mode_t mode;
    pin_map_pkg::udma_dir_t  udma_dir;
    int fails, comparisons;

    host_pin_model u_host (.mode(mode), .dma_used(dma_used), .a25(a25),
        .rd_n(rd_n), .wr_n(wr_n), .we_n(we_n), .csel_n(csel_n),
        .reg_n(reg_n), .dack_n(dack_n), .cs2_n(cs2_n), .addr(addr),
        .pin34(pin34), .pin35(pin35), .pin36(pin36), .pin39(pin39),
        .pin44(pin44), .pin_cs_hi_n(pin_cs_hi_n), .pin_addr(pin_addr));
    card_mode_pin_function_map u_dut (.clk(clk), .reset_n(reset_n),
        .mode(mode), .udma_dir(udma_dir), .host_is_8bit(host_is_8bit),
        .pin_cs_hi_n(pin_cs_hi_n), .pin34(pin34), .pin35(pin35),
        .pin36(pin36), .pin39(pin39), .pin44(pin44), .pin_addr(pin_addr),
        .core_ready(core_ready), .core_wait_n(core_wait_n),
        .core_dev_ready_n(core_dev_ready_n),
        .core_dev_strobe(core_dev_strobe), .core_ack_n(core_ack_n),
        .core_dma_req(core_dma_req), .core_is16_n(core_is16_n),
        .pin42(pin42), .pin43(pin43), .pin24(pin24),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .host_strobe(host_strobe), .host_ready_n(host_ready_n),
        .stop(stop), .write_enable_n(write_enable_n),
        .attr_select_n(attr_select_n), .dma_ack_n(dma_ack_n),
        .cable_select_n(cable_select_n), .cs_hi_n(cs_hi_n),
        .reg_addr(reg_addr), .tf_index(tf_index));

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({10'h000, got}, {10'h000, exp});
    endtask : chk1
    // pins pass three sync flops, the sync_out flop and the output register, so allow six edges
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_ide_plain;
        @(posedge clk);
        mode <= pin_map_pkg::mode_ide;
        rd_n <= 1'b0;
        core_ready <= 1'b0;
        core_dma_req <= 1'b1;
        addr <= 11'h7fd;
        csel_n <= 1'b0;
        settle;
        chk1(read_strobe_n, 1'b0);
        chk1(write_strobe_n, 1'b1);
        chk1(pin42, 1'b0);
        chk1(pin43, 1'b1);
        chk({8'h00, tf_index}, 11'h005);
        chk(reg_addr, 11'h005);
        chk1(cable_select_n, 1'b0);
        chk1(dma_ack_n, 1'b1);
        @(posedge clk);
        rd_n <= 1'b1;
        wr_n <= 1'b0;
        core_ready <= 1'b1;
        settle;
        chk1(read_strobe_n, 1'b1);
        chk1(write_strobe_n, 1'b0);
        chk1(pin42, 1'b1);
        $display("test ide_plain done");
    endtask : t_ide_plain

    task automatic t_udma;
        @(posedge clk);
        udma_dir <= pin_map_pkg::udma_write;
        dma_used <= 1'b1;
        dack_n <= 1'b0;
        rd_n <= 1'b0;
        wr_n <= 1'b1;
        core_dev_ready_n <= 1'b0;
        settle;
        chk1(host_strobe, 1'b0);
        chk1(stop, 1'b1);
        chk1(pin42, 1'b0);
        chk1(read_strobe_n, 1'b1);
        chk1(dma_ack_n, 1'b0);
        @(posedge clk);
        udma_dir <= pin_map_pkg::udma_read;
        core_dev_strobe <= 1'b1;
        settle;
        chk1(host_ready_n, 1'b0);
        chk1(pin42, 1'b1);
        @(posedge clk);
        core_dev_strobe <= 1'b0;
        @(posedge clk);
        #1;
        chk1(pin42, 1'b0);
        @(posedge clk);
        udma_dir <= pin_map_pkg::udma_none;
        dma_used <= 1'b0;
        rd_n <= 1'b1;
        $display("test udma done");
    endtask : t_udma

    task automatic t_pc;
        @(posedge clk);
        mode <= pin_map_pkg::mode_pc_io;
        reg_n <= 1'b0;
        a25 <= 1'b0;
        we_n <= 1'b0;
        core_ack_n <= 1'b0;
        core_wait_n <= 1'b0;
        core_is16_n <= 1'b0;
        addr <= 11'h2a5;
        settle;
        chk1(attr_select_n, 1'b0);
        chk1(dma_ack_n, 1'b1);
        chk1(cable_select_n, 1'b1);
        chk1(write_enable_n, 1'b0);
        chk1(pin43, 1'b0);
        chk1(pin42, 1'b0);
        chk1(pin24, 1'b0);
        chk(reg_addr, 11'h2a5);
        @(posedge clk);
        mode <= pin_map_pkg::mode_pc_mem;
        a25 <= 1'b1;
        core_is16_n <= 1'b1;
        host_is_8bit <= 1'b1;
        cs2_n <= 1'b0;
        settle;
        chk1(cable_select_n, 1'b1);
        chk1(pin24, 1'b0);
        chk1(cs_hi_n, 1'b1);
        chk(reg_addr, 11'h2a4);
        @(posedge clk);
        host_is_8bit <= 1'b0;
        settle;
        chk1(cs_hi_n, 1'b0);
        $display("test pc_modes done");
    endtask : t_pc

    task automatic print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        print_verdict;
    end

    initial begin
        {reset_n, host_is_8bit, dma_used, a25, core_ready} = 5'h00;
        {rd_n, wr_n, we_n, csel_n, reg_n, dack_n, cs2_n} = 7'h7f;
        {core_wait_n, core_dev_ready_n, core_ack_n, core_is16_n} = 4'hf;
        {core_dev_strobe, core_dma_req} = 2'h0;
        addr = 11'h000;
        mode = pin_map_pkg::mode_pc_mem;
        udma_dir = pin_map_pkg::udma_none;
        fails = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        settle;
        t_ide_plain;
        t_udma;
        t_pc;
        print_verdict;
    end
endmodule : card_mode_pin_function_map_bench
`default_nettype wire

// File: verif/host_pin_model.sv
// behavioural host controller driving the mode dependent connector inputs
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
    input  wire pin_map_pkg::card_mode_t mode,
    input  wire logic                    dma_used,
    input  wire logic                    a25,
    input  wire logic                    rd_n,
    input  wire logic                    wr_n,
    input  wire logic                    we_n,
    input  wire logic                    csel_n,
    input  wire logic                    reg_n,
    input  wire logic                    dack_n,
    input  wire logic                    cs2_n,
    input  wire logic [10:0]             addr,
    output logic                         pin34,
    output logic                         pin35,
    output logic                         pin36,
    output logic                         pin39,
    output logic                         pin44,
    output logic                         pin_cs_hi_n,
    output logic [10:0]                  pin_addr
);
    logic ide;
    // strobes, stop and host ready share pins 34 and 35 in every mode
    assign ide = (mode == pin_map_pkg::mode_ide);
    assign pin34 = rd_n;
    assign pin35 = wr_n;
    assign pin36 = ide ? 1'b1 : we_n;
    assign pin39 = ide ? csel_n : a25;
    // a host without dma keeps the acknowledge high, reads included
    assign pin44 = ide ? (dma_used ? dack_n : 1'b1) : reg_n;
    assign pin_cs_hi_n = cs2_n;
    // upper lines grounded in ide; a0 kept low on 16 bit accesses
    assign pin_addr = ide ? {8'h00, addr[2:0]} :
                      (cs2_n ? addr : {addr[10:1], 1'b0});
endmodule : host_pin_model
`default_nettype wire
